// [common/swhl_fifo_if.sv]
`default_nettype none
// Valid/ready carrier between the link engine and its reply buffer
interface swhl_fifo_if #(parameter int WIDTH = 8);
  logic wr_valid; // Producer offers a word
  logic wr_ready; // Buffer has room
  logic [WIDTH-1:0] wr_data; // Word offered
  logic rd_valid; // Buffer holds a word
  logic rd_ready; // Consumer takes the word
  logic [WIDTH-1:0] rd_data; // Oldest word
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport prod (output wr_valid, wr_data, input wr_ready);
  modport cons (input rd_valid, rd_data, output rd_ready);
endinterface
`default_nettype wire

// [common/swhl_pkg.sv]
`default_nettype none
// Shared timing figures for the single-wire host link
package swhl_pkg;
  // Clock and microsecond tick
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz system clock
  localparam int TICK_PS = 1000000; // One tick is 1 us
  localparam int TICK_CYC = (TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // Cycles per tick
  // Host side figures, in us
  localparam int BREAK_LOW_US = 190; // Least low time of a break
  localparam int BREAK_RECOVERY_US = 40; // Least high time after a break
  localparam int HOST_ONE_LOW_MAX_US = 50; // Longest host one pulse
  localparam int HOST_ZERO_LOW_MIN_US = 86; // Shortest host zero pulse
  localparam int SAMPLE_US = 68; // Receiver sample point after falling edge
  // Device side figures, in us
  localparam int DEVICE_ONE_LOW_MIN_US = 32;
  localparam int DEVICE_ONE_LOW_MAX_US = 50;
  localparam int DEVICE_ONE_LOW_US = 40; // Driven one pulse
  localparam int DEVICE_ZERO_LOW_MIN_US = 80;
  localparam int DEVICE_ZERO_LOW_MAX_US = 145;
  localparam int DEVICE_ZERO_LOW_US = 110; // Driven zero pulse
  localparam int DEVICE_BIT_CYCLE_MIN_US = 190;
  localparam int DEVICE_BIT_CYCLE_MAX_US = 250;
  localparam int DEVICE_BIT_CYCLE_US = 205; // Nominal slot
  localparam int REPLY_START_MIN_US = 190;
  localparam int REPLY_START_MAX_US = 950;
  localparam int REPLY_DELAY_US = 300; // Wait from last sample to reply
  localparam int REPLY_LATEST_US = REPLY_START_MAX_US - SAMPLE_US; // Window close from last sample
  // Long low reset
  localparam int RESET_LOW_MS = 2200; // 2.2 s
  localparam int RESET_LOW_US = RESET_LOW_MS * 1000;
  // Widths
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 22; // Holds the reset time in us
endpackage
`default_nettype wire

// [hdl/swhl_fifo.sv]
`default_nettype none
// Reply byte buffer, first in first out
module swhl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, high
  swhl_fifo_if.fifo port_if // Both handshakes
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wp; // Write pointer
  logic [AW-1:0] rp; // Read pointer
  logic [AW:0] count; // Words held
  logic do_wr; // Word accepted
  logic do_rd; // Word handed out

  // Honest flags from the occupancy count
  assign port_if.wr_ready = (count != (AW+1)'(DEPTH));
  assign port_if.rd_valid = (count != '0);
  assign port_if.rd_data = mem[rp];
  assign do_wr = port_if.wr_valid && port_if.wr_ready;
  assign do_rd = port_if.rd_ready && port_if.rd_valid;

  // Storage write, no reset needed on data
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem[wp] <= port_if.wr_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (do_rd) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

// [hdl/swhl_link.sv]
`default_nettype none
// Functional notes
// - Break is low 190 us, then 40 us high
// - Device one: low 32 to 50 us
// - Device zero: low 80 to 145 us
// - Device slot 190 to 250 us, nominal 205
// - Reply starts 190 to 950 us after command
// - Low for 2.2 s resets the device
// - Once single-wire, never back to two-wire
module swhl_link #(
  parameter int TICK_CYC = swhl_pkg::TICK_CYC, // Cycles per us tick
  parameter int RESET_LOW_US = swhl_pkg::RESET_LOW_US // Long low reset time
) (
  input wire logic clock_i, // 200 MHz clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic one_wire_sel_i, // Switch pin to single-wire use
  input wire logic line_i, // Line level, synchronous
  output logic line_o, // Line drive value, always low
  output logic line_oe_o, // Pulling the line low
  output logic one_wire_mode_o, // Pin owned by single-wire link
  output logic rx_valid_o, // Received byte pulse
  output logic [7:0] rx_data_o, // Received byte
  output logic break_o, // Break seen pulse
  output logic link_reset_o, // Long low reset pulse
  input wire logic tx_valid_i, // Reply byte offered
  input wire logic [7:0] tx_data_i, // Reply byte
  output logic tx_ready_o, // Reply buffer has room
  output logic tx_busy_o // Device is driving a reply
);
  typedef enum logic [1:0] {S_OFF, S_RECOVER, S_LISTEN, S_TX} swhl_state_e;
  localparam int CW = swhl_pkg::CNT_W;
  localparam int DW = $clog2(TICK_CYC + 1); // Divider width

  swhl_state_e state; // Link state
  logic [DW-1:0] div; // Tick divider
  logic tick; // One-cycle 1 us enable
  logic line_q; // Line one cycle ago
  logic fall; // Falling line edge
  logic rise; // Rising line edge
  logic [CW-1:0] low_us; // Time line has been low
  logic [CW-1:0] next_low_us; // Incremented low time
  logic [7:0] high_us; // High time in recovery
  logic [7:0] slot_us; // Time inside current slot
  logic slot_act; // Host slot awaiting sample
  logic [2:0] bit_cnt; // Bits of current byte
  logic [7:0] shift; // Receive shifter
  logic sample; // Sample strobe
  logic win_act; // Reply window open
  logic [9:0] win_us; // Time since last command bit
  logic [7:0] tx_sh; // Transmit shifter
  logic [7:0] low_len; // Low length of current bit
  logic slot_end; // Last tick of device slot
  logic load; // Take a reply byte
  swhl_fifo_if #(.WIDTH(8)) fq ();

  // Reply buffer: filled by the user, drained only while replying
  swhl_fifo #(.WIDTH(8), .DEPTH(swhl_pkg::FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .port_if(fq.fifo)
  );
  assign fq.wr_valid = tx_valid_i;
  assign fq.wr_data = tx_data_i;
  assign tx_ready_o = fq.wr_ready;
  assign fq.rd_ready = load;

  assign line_o = 1'b0;
  assign fall = line_q && !line_i;
  assign rise = !line_q && line_i;
  assign next_low_us = (low_us == CW'(RESET_LOW_US)) ? low_us : low_us + 1'b1;
  assign sample = tick && state == S_LISTEN && slot_act && slot_us == 8'(swhl_pkg::SAMPLE_US - 1);
  assign low_len = tx_sh[0] ? 8'(swhl_pkg::DEVICE_ONE_LOW_US) : 8'(swhl_pkg::DEVICE_ZERO_LOW_US);
  assign slot_end = tick && state == S_TX && slot_us == 8'(swhl_pkg::DEVICE_BIT_CYCLE_US - 1);
  // Start a reply after the delay, or chain the next byte without a gap
  always_comb begin
    load = 1'b0;
    if (fq.rd_valid && tick) begin
      if (state == S_LISTEN && win_act && win_us >= 10'(swhl_pkg::REPLY_DELAY_US)) begin
        load = 1'b1;
      end else if (slot_end && bit_cnt == 3'd7) begin
        load = 1'b1;
      end
    end
  end

  // Microsecond tick divider
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || div == DW'(TICK_CYC - 1)) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = (div == DW'(TICK_CYC - 1));

  // Pin ownership never returns to two-wire use
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      one_wire_mode_o <= 1'b0;
    end else if (one_wire_sel_i) begin
      one_wire_mode_o <= 1'b1;
    end
  end

  // Line history for edge detection; idle line is high
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      line_q <= 1'b1;
    end else begin
      line_q <= line_i;
    end
  end

  // Low-time measure, break and long low reset
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      low_us <= '0;
      break_o <= 1'b0;
      link_reset_o <= 1'b0;
    end else begin
      break_o <= 1'b0;
      link_reset_o <= 1'b0;
      if (state == S_OFF || state == S_TX || line_i) begin
        low_us <= '0; // Own drive is not a host low
      end else if (tick) begin
        low_us <= next_low_us;
        if (low_us != next_low_us && next_low_us == CW'(RESET_LOW_US)) begin
          link_reset_o <= 1'b1;
        end
      end
      if (rise && state != S_OFF && state != S_TX && low_us >= CW'(swhl_pkg::BREAK_LOW_US)) begin
        break_o <= 1'b1;
      end
    end
  end

  // Link state machine
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= S_OFF;
    end else begin
      unique case (state)
        S_OFF: begin
          if (one_wire_mode_o) begin
            state <= S_RECOVER; // Wait for the line to stay high for the recovery time
          end
        end
        S_RECOVER: begin
          // One tick short of the full figure: tick phase can cost up to a tick,
          // and a host giving exactly the minimum recovery must not lose its first bit
          if (tick && line_i && high_us == 8'(swhl_pkg::BREAK_RECOVERY_US - 2)) begin
            state <= S_LISTEN;
          end
        end
        S_LISTEN: begin
          if (rise && low_us >= CW'(swhl_pkg::BREAK_LOW_US)) begin
            state <= S_RECOVER;
          end else if (load) begin
            state <= S_TX;
          end
        end
        S_TX: begin
          if (slot_end && bit_cnt == 3'd7 && !load) begin
            state <= S_LISTEN; // Host keeps the turnaround gap
          end
        end
      endcase
    end
  end

  // High time counted only while recovering from a break
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state != S_RECOVER || !line_i) begin
      high_us <= '0;
    end else if (tick) begin
      high_us <= high_us + 1'b1;
    end
  end

  // Slot timer, bit counter and both shifters
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      slot_act <= 1'b0;
      slot_us <= '0;
      bit_cnt <= '0;
      shift <= '0;
      tx_sh <= '0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      rx_valid_o <= 1'b0;
      if (load) begin
        tx_sh <= fq.rd_data;
        slot_us <= '0;
        bit_cnt <= '0;
      end else if (state == S_TX) begin
        if (slot_end) begin
          slot_us <= '0;
          tx_sh <= {1'b0, tx_sh[7:1]};
          bit_cnt <= bit_cnt + 1'b1;
        end else if (tick) begin
          slot_us <= slot_us + 1'b1;
        end
      end else if (state != S_LISTEN) begin
        slot_act <= 1'b0;
        bit_cnt <= '0; // Break drops a partial byte
      end else if (fall) begin
        slot_act <= 1'b1;
        slot_us <= '0;
      end else if (sample) begin
        slot_act <= 1'b0;
        shift <= {line_i, shift[7:1]};
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == 3'd7) begin
          rx_valid_o <= 1'b1;
          rx_data_o <= {line_i, shift[7:1]};
        end
      end else if (tick && slot_act) begin
        slot_us <= slot_us + 1'b1;
      end
    end
  end

  // Reply window opens at each full byte, shuts on host activity
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state != S_LISTEN || fall || load) begin
      win_act <= 1'b0;
      win_us <= '0;
    end else if (sample && bit_cnt == 3'd7) begin
      win_act <= 1'b1;
      win_us <= '0;
    end else if (tick && win_act) begin
      win_us <= win_us + 1'b1;
      if (win_us == 10'(swhl_pkg::REPLY_LATEST_US - 1)) begin
        win_act <= 1'b0; // Too late to answer
      end
    end
  end

  // Pulse width coder, aligned to ticks
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      line_oe_o <= 1'b0;
    end else if (load) begin
      line_oe_o <= 1'b1;
    end else if (slot_end && bit_cnt != 3'd7) begin
      line_oe_o <= 1'b1;
    end else if (tick && state == S_TX && slot_us == low_len - 8'd1) begin
      line_oe_o <= 1'b0;
    end
  end
  assign tx_busy_o = (state == S_TX);

  // Checking helpers: drive and slot lengths in cycles
  int drv_cyc;
  int gap_cyc;
  logic in_burst;
  logic cur_bit;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      drv_cyc <= 0;
      gap_cyc <= 0;
      in_burst <= 1'b0;
      cur_bit <= 1'b0;
    end else begin
      drv_cyc <= line_oe_o ? drv_cyc + 1 : 0;
      gap_cyc <= (line_oe_o && !$past(line_oe_o)) ? 1 : gap_cyc + 1;
      in_burst <= (state == S_TX);
      if (line_oe_o && !$past(line_oe_o)) begin
        cur_bit <= tx_sh[0];
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_long_low;
    !line_i && low_us >= CW'(swhl_pkg::BREAK_LOW_US) && state == S_LISTEN;
  endsequence
  sequence s_release;
    line_i;
  endsequence

  a_break_detect: assert property (s_long_low ##1 s_release |=> break_o ##1 state == S_RECOVER)
    else $error("break not flagged");
  a_one_width: assert property ($fell(line_oe_o) && cur_bit |->
    drv_cyc >= swhl_pkg::DEVICE_ONE_LOW_MIN_US * TICK_CYC && drv_cyc <= swhl_pkg::DEVICE_ONE_LOW_MAX_US * TICK_CYC)
    else $error("one pulse width wrong");
  a_zero_width: assert property ($fell(line_oe_o) && !cur_bit |->
    drv_cyc >= swhl_pkg::DEVICE_ZERO_LOW_MIN_US * TICK_CYC && drv_cyc <= swhl_pkg::DEVICE_ZERO_LOW_MAX_US * TICK_CYC)
    else $error("zero pulse width wrong");
  a_slot_length: assert property ($rose(line_oe_o) && in_burst |->
    gap_cyc >= swhl_pkg::DEVICE_BIT_CYCLE_MIN_US * TICK_CYC && gap_cyc <= swhl_pkg::DEVICE_BIT_CYCLE_MAX_US * TICK_CYC)
    else $error("device slot length wrong");
  a_reply_window: assert property (state == S_LISTEN && load |->
    win_us >= 10'(swhl_pkg::REPLY_DELAY_US) && win_us < 10'(swhl_pkg::REPLY_LATEST_US) ##1 line_oe_o)
    else $error("reply start outside window");
  a_reset_pulse: assert property (link_reset_o |-> low_us == CW'(RESET_LOW_US) && !line_q)
    else $error("link reset without long low");
  a_mode_sticky: assert property (one_wire_mode_o |=> one_wire_mode_o)
    else $error("left single-wire mode");
  a_sample_point: assert property (sample |=> shift[7] == $past(line_i) && !slot_act)
    else $error("bit sampled wrongly");
  a_byte_lsb: assert property (load |=> tx_sh[0] == $past(fq.rd_data[0]) && line_oe_o)
    else $error("reply not lsb first");
endmodule
`default_nettype wire

// [verif/swhl_host.sv]
`default_nettype none
// Behavioural host controller on the single-wire line
module swhl_host #(
  parameter int TICK = 4 // Clock cycles per us
) (
  input wire logic clock_i, // System clock
  input wire logic line_i, // Resolved line level
  output logic low_o // Host pulls the line low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int US = 5 * TICK; // Nanoseconds per us
  int errs = 0; // Mismatches seen here
  int checks = 0; // Comparisons made here
  longint t_rel = 0; // Release of the last host pulse
  longint t_fall = 0; // Last device falling edge
  initial low_o = 1'b0;
  // Local comparison
  task automatic ck(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      errs++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // Whole us spans, always ending just after a falling clock edge
  task automatic wait_us(input int n);
    repeat (n * TICK) @(negedge clock_i);
  endtask
  // One low pulse, then high for the rest of the slot
  task automatic pull(input int low_us, input int slot_us);
    low_o = 1'b1;
    wait_us(low_us);
    low_o = 1'b0;
    t_rel = $time;
    wait_us(slot_us - low_us);
  endtask
  task automatic send_break(input int low_us);
    pull(low_us, low_us + 40);
  endtask
  // Bits go out low bit first; a short count leaves a partial byte
  task automatic send_byte(input logic [7:0] b, input int nbits);
    int lo;
    for (int i = 0; i < nbits; i++) begin
      lo = b[i] ? $urandom_range(50, 1) : $urandom_range(145, 86);
      pull(lo, 190 + $urandom_range(20, 0));
    end
  endtask
  // Long low, far past a break
  task automatic hold_low(input int us);
    low_o = 1'b1;
    wait_us(us);
    low_o = 1'b0;
  endtask
  // Decode one reply byte from pulse widths; timeouts show up as bad spans
  task automatic recv_byte(output logic [7:0] b, input logic first);
    int n;
    int lo;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (line_i !== 1'b0 && n < 1000 * TICK) begin
        @(negedge clock_i);
        n++;
      end
      if (first && i == 0) ck(($time - t_rel) / US >= 190 && ($time - t_rel) / US <= 950, "reply start");
      else ck(($time - t_fall) / US >= 190 && ($time - t_fall) / US <= 250, "device slot");
      t_fall = $time;
      lo = 0;
      while (line_i === 1'b0 && lo < 200 * TICK) begin
        @(negedge clock_i);
        lo++;
      end
      lo = lo / TICK;
      ck((lo >= 32 && lo <= 50) || (lo >= 80 && lo <= 145), "device low time");
      b[i] = (lo <= 50);
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb_single_wire_host_link.sv]
`default_nettype none
// Self-checking bench for the link engine
module tb_single_wire_host_link;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4; // Shortened us tick
  localparam int RST_US = 400; // Shortened long-low reset
  logic clock_i, sys_rst_i, one_wire_sel_i, tx_valid_i;
  logic [7:0] tx_data_i;
  logic line_o, line_oe, mode, rx_valid, brk, lrst, tx_ready, tx_busy, host_low;
  logic [7:0] rx_data;
  wire logic line; // Open-drain wire with pull-up
  int fail_count = 0;
  int num_checks = 0;
  int n_brk = 0; // Break pulses seen
  int n_lrst = 0; // Long-low resets seen
  logic [7:0] exp_rx[$]; // Bytes the host sent
  logic [7:0] exp_tx[$]; // Bytes the buffer took
  assign line = ~(host_low | (line_oe & ~line_o));
  swhl_link #(.TICK_CYC(TICK), .RESET_LOW_US(RST_US)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .one_wire_sel_i(one_wire_sel_i), .line_i(line), .line_o(line_o), .line_oe_o(line_oe),
    .one_wire_mode_o(mode), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .break_o(brk),
    .link_reset_o(lrst), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready),
    .tx_busy_o(tx_busy));
  swhl_host host_u (.clock_i(clock_i), .line_i(line), .low_o(host_low)); // Default tick equals TICK
  task automatic ck(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // Verdict, shared by the main sequence and the watchdog
  task automatic end_of_test();
    fail_count += host_u.errs;
    num_checks += host_u.checks;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Pulse monitor; every received byte is matched against the queue
  always @(posedge clock_i) begin
    if (brk === 1'b1) n_brk++;
    if (lrst === 1'b1) n_lrst++;
    if (rx_valid === 1'b1) begin
      if (exp_rx.size() == 0) ck(1'b0, "unexpected byte");
      else ck(rx_data === exp_rx.pop_front(), "received byte");
    end
  end
  // Main sequence
  initial begin
    logic [7:0] b;
    int k;
    sys_rst_i = 1'b1;
    one_wire_sel_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = 8'h00;
    k = $urandom(32'h8413192e);
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    @(negedge clock_i);
    ck(line_oe === 1'b0 && line_o === 1'b0 && mode === 1'b0 && tx_ready === 1'b1, "reset values");
    $display("test reset done");
    // One-cycle select pulse must stick
    one_wire_sel_i = 1'b1;
    @(negedge clock_i);
    one_wire_sel_i = 1'b0;
    host_u.wait_us(50);
    ck(mode === 1'b1, "mode set");
    host_u.send_break(190);
    ck(n_brk == 1, "minimum break");
    b = 8'($urandom);
    exp_rx.push_back(b);
    host_u.send_byte(b, 8);
    // Partial byte cut off by a break must be dropped
    host_u.send_byte(8'h5a, 3);
    host_u.send_break(250);
    exp_rx.push_back(8'hc3);
    host_u.send_byte(8'hc3, 8);
    ck(exp_rx.size() == 0 && n_brk == 2 && n_lrst == 0, "bytes and breaks");
    $display("test host bytes done");
    // Fill the reply buffer until it refuses
    // Let the last byte's reply window lapse so the buffer is not drained early
    host_u.wait_us(900);
    k = 0;
    while (tx_ready === 1'b1 && k < 20) begin
      tx_valid_i = 1'($urandom);
      tx_data_i = 8'($urandom);
      @(posedge clock_i);
      if (tx_valid_i) begin
        exp_tx.push_back(tx_data_i);
        k++;
      end
      @(negedge clock_i);
    end
    tx_valid_i = 1'b1;
    tx_data_i = 8'hee;
    @(negedge clock_i);
    tx_valid_i = 1'b0;
    ck(k == 8 && tx_ready === 1'b0, "buffer full at eight");
    b = 8'($urandom);
    exp_rx.push_back(b);
    host_u.send_byte(b, 8);
    // Reply bytes must chain back to back and match the buffer order
    for (int i = 0; i < 8; i++) begin
      host_u.recv_byte(b, i == 0);
      ck(b === exp_tx.pop_front(), "reply byte");
      if (i == 0) ck(tx_busy === 1'b1, "busy in reply");
    end
    host_u.wait_us(250);
    ck(tx_busy === 1'b0 && tx_ready === 1'b1 && line_oe === 1'b0, "reply over");
    $display("test reply done");
    // Long low resets the device but keeps the pin mode
    k = n_lrst;
    host_u.hold_low(RST_US + 10);
    host_u.wait_us(50);
    ck(n_lrst == k + 1 && mode === 1'b1, "long low reset");
    $display("test long low done");
    end_of_test();
  end
  // Watchdog sized at less than a quarter more than the expected run
  initial begin
    repeat (99000) @(posedge clock_i);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
